// ---- core/alr_regs.svh ----
// constants for the adapter link recognition block
// assumes a 50 MHz system clock; included by package and modules
`ifndef ALR_REGS_SVH
`define ALR_REGS_SVH

`define ALR_STX 8'h02
`define ALR_KIND_RECOG 16'hFFFF
`define ALR_CMD_REQ 8'h00
`define ALR_CMD_NOTE 8'h01
`define ALR_CMD_DATA 8'h80
`define ALR_CMD_ACC 8'h81
`define ALR_LEN_NONE 16'h0000
`define ALR_LEN_ONE 16'h0001
`define ALR_RES_OK 8'h00
`define ALR_RES_NG 8'h01
`define ALR_SEQ_NONE 8'h00
`define ALR_IFD_SEQ_HI 7
`define ALR_IFD_SEQ_LO 6
`define ALR_IFD_FEAT_HI 5
`define ALR_IFD_FEAT_LO 3
`define ALR_SEQ_POLL 2'h1
`define ALR_SEQ_BIDIR 2'h3
`define ALR_MCLK_HZ 50000000
`define ALR_MS_CYC (`ALR_MCLK_HZ / 1000)
`define ALR_REPLY_MS 10'h12C
`define ALR_TRANS_MS 10'h1F4
`define ALR_RETRY_GAP_MS 10'h064
`define ALR_MAX_RECOVER 3
`define ALR_N_SPEEDS 7
`define ALR_START_SPEED 3'h2

`endif

// ---- core/alr_pkg.sv ----
// types shared by both ends of the recognition link
// assumes alr_regs.svh is on the include path
`include "alr_regs.svh"
package alr_pkg;
    typedef struct packed {
        logic [7:0] frame_start_code;
        logic [15:0] frame_kind;
        logic [7:0] command_code;
        logic [7:0] frame_seq_number;
        logic [15:0] payload_length;
        logic [7:0] data;
        logic [2:0] speed;
        logic [7:0] frame_check_code;
    } alr_frame_s;

    typedef enum logic [2:0] {
        ALR_A_REQ = 3'h0,
        ALR_A_WDATA = 3'h1,
        ALR_A_WACC = 3'h3,
        ALR_A_TRANS = 3'h2,
        ALR_A_UNCONF = 3'h6,
        ALR_A_CONF = 3'h7,
        ALR_A_GAP = 3'h5,
        ALR_A_NOCONN = 3'h4
    } alr_astate_e;

    typedef enum logic [2:0] {
        ALR_E_WREQ = 3'h0,
        ALR_E_WNOTE = 3'h1,
        ALR_E_TRANS = 3'h3,
        ALR_E_UNCONF = 3'h2,
        ALR_E_CONF = 3'h6
    } alr_estate_e;

    // check byte: byte sum of everything after the start code
    function automatic logic [7:0] alr_check(input alr_frame_s f);
        logic [7:0] s;
        s = f.frame_kind[15:8] + f.frame_kind[7:0] + f.command_code + f.frame_seq_number
            + f.payload_length[15:8] + f.payload_length[7:0];
        if (f.payload_length != `ALR_LEN_NONE) begin
            s = s + f.data;
        end
        return s;
    endfunction : alr_check

    function automatic alr_frame_s alr_mk_frame(input logic [7:0] cmd, input logic [7:0] seq,
                                                input logic [15:0] len, input logic [7:0] data,
                                                input logic [2:0] speed);
        alr_frame_s f;
        f.frame_start_code = `ALR_STX;
        f.frame_kind = `ALR_KIND_RECOG;
        f.command_code = cmd;
        f.frame_seq_number = seq;
        f.payload_length = len;
        f.data = (len == `ALR_LEN_NONE) ? 8'h00 : data;
        f.speed = speed;
        f.frame_check_code = 8'h00;
        f.frame_check_code = alr_check(f);
        return f;
    endfunction : alr_mk_frame

    function automatic logic alr_frame_ok(input alr_frame_s f);
        return (f.frame_start_code == `ALR_STX) && (f.frame_kind == `ALR_KIND_RECOG)
            && (f.frame_check_code == alr_check(f));
    endfunction : alr_frame_ok
endpackage : alr_pkg

// ---- core/alr_link_if.sv ----
// frame-level serial link between adapter and equipment
// one frame per valid pulse each way; both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface alr_link_if;
    logic a2e_valid;
    alr_pkg::alr_frame_s a2e_frame;
    logic e2a_valid;
    alr_pkg::alr_frame_s e2a_frame;

    modport adapter (output a2e_valid, output a2e_frame, input e2a_valid, input e2a_frame);
    modport equip (input a2e_valid, input a2e_frame, output e2a_valid, output e2a_frame);
endinterface : alr_link_if
`default_nettype wire

// ---- core/alr_equip.sv ----
// equipment end of the recognition link
// assumes the adapter drives requests and notifications on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "alr_regs.svh"
module alr_equip #(
    parameter int unsigned CYC_PER_MS = `ALR_MS_CYC,
    parameter int unsigned MAX_RECOVER = `ALR_MAX_RECOVER,
    parameter bit SEQ_EN = 1'b1,
    parameter bit START_RECOG = 1'b0,
    parameter logic [2:0] START_SPEED = `ALR_START_SPEED
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    alr_link_if.equip link,
    input wire logic [2:0] i_speed,
    input wire logic [7:0] i_if_data,
    input wire logic i_confirm_ok,
    input wire logic i_comm_fail,
    input wire logic i_recover_ok,
    output alr_pkg::alr_estate_e o_state,
    output logic [2:0] o_speed,
    output logic o_recognized,
    output logic o_confirmed,
    output logic o_rejected
);
    import alr_pkg::*;

    if (CYC_PER_MS < 2 || CYC_PER_MS > 65536) begin : g_bad_div
        $error("CYC_PER_MS out of range");
    end
    if (MAX_RECOVER < 1 || MAX_RECOVER > 15) begin : g_bad_rcv
        $error("MAX_RECOVER out of range");
    end

    typedef struct packed {
        alr_estate_e st;
        logic [15:0] div;
        logic [9:0] ms;
        logic [2:0] spd;
        logic [3:0] rcv;
        logic tx_v;
        alr_frame_s tx;
        logic rec;
        logic conf;
        logic rej;
    } alr_estate_s;

    alr_estate_s r;
    alr_estate_s n;
    alr_frame_s f;
    logic rx_req;
    logic rx_note;

    assign f = link.a2e_frame;
    // a frame sent at another speed is noise to this end
    assign rx_req = link.a2e_valid && alr_frame_ok(f) && f.speed == i_speed
        && f.command_code == `ALR_CMD_REQ; // R4
    assign rx_note = link.a2e_valid && alr_frame_ok(f) && f.speed == r.spd
        && f.command_code == `ALR_CMD_NOTE && f.payload_length == `ALR_LEN_ONE;

    always_comb begin
        n = r;
        n.tx_v = 1'b0;
        n.rej = 1'b0;
        n.div = (r.div == 16'(CYC_PER_MS - 1)) ? 16'h0000 : r.div + 16'h0001;
        if (r.div == 16'(CYC_PER_MS - 1) && r.ms != 10'h3FF) begin
            n.ms = r.ms + 10'h001;
        end
        if (rx_req) begin
            // only answers, never opens an exchange
            n.tx_v = 1'b1; // R11
            n.tx = alr_mk_frame(`ALR_CMD_DATA, SEQ_EN ? f.frame_seq_number : `ALR_SEQ_NONE,
                                `ALR_LEN_ONE, i_if_data, i_speed);
            n.spd = i_speed;
            n.st = ALR_E_WNOTE; // R3
        end else begin
            unique case (r.st)
                ALR_E_WREQ: begin
                end
                ALR_E_WNOTE: begin
                    if (rx_note && f.data == `ALR_RES_OK) begin
                        n.tx_v = 1'b1; // R19
                        n.tx = alr_mk_frame(`ALR_CMD_ACC, SEQ_EN ? f.frame_seq_number : `ALR_SEQ_NONE,
                                            `ALR_LEN_NONE, 8'h00, r.spd); // R1 R2
                        n.st = ALR_E_TRANS; // R12
                    end else if (rx_note) begin
                        n.rej = 1'b1;
                        n.st = ALR_E_WREQ; // R12
                    end
                end
                ALR_E_TRANS: begin
                    if (r.ms >= `ALR_TRANS_MS) begin
                        n.st = ALR_E_UNCONF; // R7
                    end
                end
                ALR_E_UNCONF, ALR_E_CONF: begin
                    if (i_comm_fail) begin
                        // recovery by repeated attempts, then back to hunting
                        if (r.rcv == 4'(MAX_RECOVER - 1)) begin
                            n.st = ALR_E_WREQ; // R6
                        end else begin
                            n.rcv = r.rcv + 4'h1; // R6
                        end
                    end else if (i_recover_ok) begin
                        n.rcv = 4'h0;
                    end else if (r.st == ALR_E_UNCONF && i_confirm_ok) begin
                        n.st = ALR_E_CONF;
                    end
                end
                default: begin
                    n.st = ALR_E_WREQ;
                end
            endcase
        end
        if (n.st != r.st) begin
            n.div = 16'h0000;
            n.ms = 10'h000;
            n.rcv = 4'h0;
        end
        n.rec = (n.st == ALR_E_TRANS) || (n.st == ALR_E_UNCONF) || (n.st == ALR_E_CONF); // R5
        n.conf = (n.st == ALR_E_CONF);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            r <= '0;
            r.st <= START_RECOG ? ALR_E_UNCONF : ALR_E_WREQ; // R10
            r.spd <= START_SPEED;
            r.rec <= START_RECOG;
        end else begin
            r <= n;
        end
    end

    assign link.e2a_valid = r.tx_v;
    assign link.e2a_frame = r.tx;
    assign o_state = r.st;
    assign o_speed = r.spd;
    assign o_recognized = r.rec;
    assign o_confirmed = r.conf;
    assign o_rejected = r.rej;
endmodule : alr_equip
`default_nettype wire

// ---- core/alr_adapter.sv ----
// adapter end of the recognition link: speed hunt, notification,
// switch-over delay, confirmation and recovery
// assumes the equipment answers on the same clock through alr_link_if
`timescale 1ns/100ps
`default_nettype none
`include "alr_regs.svh"
// Notes on behaviour
// R1: acceptance frame: 0x02, 0xFFFF, 0x81, no data
// R2: acceptance sequence echoes request, else zero (code echoes the notification's number)
// R3: stay unrecognized until recognition succeeds
// R4: while unrecognized, try each speed in turn
// R5: after recognition, use recognized method only
// R6: on failure recover, else back to unrecognized
// R7: switch-over delay is at least 500 ms
// R8: bad response: retry after retry gap
// R9: adapter may rerun confirmation after failure
// R10: power-on start state chosen by parameter
// R11: equipment waits for adapter's request
// R12: equipment: reject goes waiting, accept answers
// R13: adapter keeps requesting, cycling two+ speeds
// R14: good data: notify positive, await acceptance
// R15: unusable method: notify negative, no connection
// R16: no connection: abort handling
// R17: unconfirmed: confirm, then confirmed
// R18: speed order, attempts and gap are parameters (code: order fixed ascending from START_SPEED over N_SPEEDS)
// R19: equipment accepts within 300 ms
// R20: acceptance within 300 ms, else re-request
module alr_adapter #(
    parameter int unsigned CYC_PER_MS = `ALR_MS_CYC,
    parameter int unsigned N_SPEEDS = `ALR_N_SPEEDS,
    parameter logic [9:0] RETRY_GAP_MS = `ALR_RETRY_GAP_MS,
    parameter int unsigned MAX_RECOVER = `ALR_MAX_RECOVER,
    parameter bit START_RECOG = 1'b0,
    parameter logic [2:0] START_SPEED = `ALR_START_SPEED
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    alr_link_if.adapter link,
    input wire logic [2:0] i_feat_mask,
    input wire logic i_confirm_ok,
    input wire logic i_confirm_fail,
    input wire logic i_comm_fail,
    input wire logic i_recover_ok,
    input wire logic i_reconfirm,
    output alr_pkg::alr_astate_e o_state,
    output logic [2:0] o_speed,
    output logic [7:0] o_if_data,
    output logic o_recognized,
    output logic o_confirmed,
    output logic o_abort
);
    import alr_pkg::*;

    // at least two speeds are needed for a real hunt
    if (N_SPEEDS < 2 || N_SPEEDS > 7) begin : g_bad_spd // R13
        $error("N_SPEEDS out of range");
    end
    if (CYC_PER_MS < 2 || CYC_PER_MS > 65536) begin : g_bad_div
        $error("CYC_PER_MS out of range");
    end
    if (MAX_RECOVER < 1 || MAX_RECOVER > 15) begin : g_bad_rcv
        $error("MAX_RECOVER out of range");
    end
    if (RETRY_GAP_MS == 10'h000) begin : g_bad_gap
        $error("RETRY_GAP_MS must be nonzero");
    end

    typedef struct packed {
        alr_astate_e st;
        logic [15:0] div;
        logic [9:0] ms;
        logic [2:0] spd;
        logic [7:0] seq;
        logic [7:0] ifd;
        logic [3:0] rcv;
        logic tx_v;
        alr_frame_s tx;
        logic rec;
        logic conf;
        logic abort;
    } alr_astate_s;

    alr_astate_s r;
    alr_astate_s n;
    alr_frame_s f;
    logic rx_ok;
    logic seq_ok;
    logic [1:0] ifd_seq;
    logic [2:0] ifd_feat;
    logic usable;

    assign f = link.e2a_frame;
    // replies heard at another speed are discarded, not misread
    assign rx_ok = link.e2a_valid && f.speed == r.spd && alr_frame_ok(f);
    // equipment without sequence support answers zero
    assign seq_ok = (f.frame_seq_number == r.seq - 8'h01) || (f.frame_seq_number == `ALR_SEQ_NONE); // R2
    assign ifd_seq = f.data[`ALR_IFD_SEQ_HI:`ALR_IFD_SEQ_LO];
    assign ifd_feat = f.data[`ALR_IFD_FEAT_HI:`ALR_IFD_FEAT_LO];
    assign usable = (ifd_seq == `ALR_SEQ_POLL || ifd_seq == `ALR_SEQ_BIDIR)
        && ((ifd_feat & ~i_feat_mask) == 3'h0);

    always_comb begin
        n = r;
        n.tx_v = 1'b0;
        n.abort = 1'b0;
        n.div = (r.div == 16'(CYC_PER_MS - 1)) ? 16'h0000 : r.div + 16'h0001;
        if (r.div == 16'(CYC_PER_MS - 1) && r.ms != 10'h3FF) begin
            n.ms = r.ms + 10'h001;
        end
        unique case (r.st)
            ALR_A_REQ: begin
                n.tx_v = 1'b1; // R13
                n.tx = alr_mk_frame(`ALR_CMD_REQ, r.seq, `ALR_LEN_NONE, 8'h00, r.spd);
                n.seq = r.seq + 8'h01;
                n.st = ALR_A_WDATA;
            end
            ALR_A_WDATA: begin
                if (rx_ok && f.command_code == `ALR_CMD_DATA && f.payload_length == `ALR_LEN_ONE
                    && seq_ok) begin
                    n.ifd = f.data;
                    n.tx_v = 1'b1;
                    n.tx = alr_mk_frame(`ALR_CMD_NOTE, r.seq, `ALR_LEN_ONE,
                                        usable ? `ALR_RES_OK : `ALR_RES_NG, r.spd); // R14 R15
                    n.seq = r.seq + 8'h01;
                    if (usable) begin
                        n.st = ALR_A_WACC; // R14
                    end else begin
                        n.st = ALR_A_NOCONN; // R15
                        n.abort = 1'b1; // R16
                    end
                end else if (rx_ok || link.e2a_valid && f.speed == r.spd) begin
                    n.st = ALR_A_GAP; // R8
                end else if (r.ms == `ALR_REPLY_MS) begin
                    n.st = ALR_A_GAP; // R3
                end
            end
            ALR_A_WACC: begin
                if (rx_ok && f.command_code == `ALR_CMD_ACC && f.payload_length == `ALR_LEN_NONE
                    && seq_ok) begin // R1
                    n.st = ALR_A_TRANS; // R20
                end else if (r.ms == `ALR_REPLY_MS) begin
                    n.st = ALR_A_REQ; // R20
                end
            end
            ALR_A_GAP: begin
                if (r.ms >= RETRY_GAP_MS) begin
                    // fixed ascending order; wraps after the last speed
                    n.spd = (r.spd >= 3'(N_SPEEDS - 1)) ? 3'h0 : r.spd + 3'h1; // R4 R18
                    n.st = ALR_A_REQ; // R13
                end
            end
            ALR_A_TRANS: begin
                // the far end retunes in this time; nothing is sent
                if (r.ms >= `ALR_TRANS_MS) begin
                    n.st = ALR_A_UNCONF; // R7
                end
            end
            ALR_A_UNCONF, ALR_A_CONF: begin
                if (i_comm_fail || (r.st == ALR_A_UNCONF && i_confirm_fail)) begin
                    if (r.rcv == 4'(MAX_RECOVER - 1)) begin
                        n.st = ALR_A_GAP; // R6
                    end else begin
                        n.rcv = r.rcv + 4'h1; // R6
                    end
                end else if (i_recover_ok) begin
                    n.rcv = 4'h0;
                end else if (r.st == ALR_A_UNCONF && i_confirm_ok) begin
                    n.st = ALR_A_CONF; // R17
                end else if (r.st == ALR_A_CONF && i_reconfirm) begin
                    n.st = ALR_A_UNCONF; // R9
                end
            end
            ALR_A_NOCONN: begin
                // terminal until reset: no method both sides accept
            end
        endcase
        if (n.st != r.st) begin
            n.div = 16'h0000;
            n.ms = 10'h000;
            if (n.st != ALR_A_UNCONF && n.st != ALR_A_CONF) begin
                n.rcv = 4'h0;
            end
        end
        // speed is frozen once recognized
        n.rec = (n.st == ALR_A_TRANS) || (n.st == ALR_A_UNCONF) || (n.st == ALR_A_CONF); // R5
        n.conf = (n.st == ALR_A_CONF);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            r <= '0;
            r.st <= START_RECOG ? ALR_A_UNCONF : ALR_A_REQ; // R10
            r.spd <= START_SPEED;
            r.rec <= START_RECOG;
        end else begin
            r <= n;
        end
    end

    assign link.a2e_valid = r.tx_v;
    assign link.a2e_frame = r.tx;
    assign o_state = r.st;
    assign o_speed = r.spd;
    assign o_if_data = r.ifd;
    assign o_recognized = r.rec;
    assign o_confirmed = r.conf;
    assign o_abort = r.abort;
endmodule : alr_adapter
`default_nettype wire

// ---- bench/alr_link_assertions.sv ----
// concurrent checks on the frame link between adapter and equipment
// assumes both ends share i_mclk; instantiated beside the link interface
`timescale 1ns/100ps
`default_nettype none
module alr_link_assertions #(
    parameter int unsigned CYC_PER_MS = 4
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic a2e_valid,
    input wire alr_pkg::alr_frame_s a2e_frame,
    input wire logic e2a_valid,
    input wire alr_pkg::alr_frame_s e2a_frame
);
    import alr_pkg::*;
    // unanswered request: full reply window plus retry gap before the next
    localparam int GAPC = 400 * CYC_PER_MS - 1;
    int gap_cnt_r;
    logic armed_r;
    logic is_acc;
    logic is_note;
    assign is_acc = e2a_valid && (e2a_frame.command_code == 8'h81);
    assign is_note = a2e_valid && (a2e_frame.command_code == 8'h01);
    // saturating count keeps the comparison cheap on long hunts
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            gap_cnt_r <= 0;
            armed_r <= 1'b0;
        end else if (e2a_valid) begin
            armed_r <= 1'b0;
        end else if (a2e_valid && (a2e_frame.command_code == 8'h00)) begin
            armed_r <= 1'b1;
            gap_cnt_r <= 0;
        end else if (gap_cnt_r < GAPC) begin
            gap_cnt_r <= gap_cnt_r + 1;
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    chk_acc_format: assert property (is_acc |-> e2a_frame.frame_start_code == 8'h02
        && e2a_frame.frame_kind == 16'hFFFF && e2a_frame.payload_length == 16'h0000)
        else $error("acceptance frame layout wrong");
    chk_acc_seq: assert property (is_acc |-> $past(is_note)
        && e2a_frame.frame_seq_number == $past(a2e_frame.frame_seq_number))
        else $error("acceptance sequence not echoed");
    chk_equip_waits: assert property (e2a_valid |-> $past(a2e_valid))
        else $error("equipment sent without a request");
    chk_speed_kept: assert property (e2a_valid |-> e2a_frame.speed == $past(a2e_frame.speed))
        else $error("reply speed differs from request");
    chk_accept_yes: assert property (is_note && a2e_frame.data == 8'h00 |=> is_acc)
        else $error("positive notification not accepted");
    chk_accept_no: assert property (is_note && a2e_frame.data != 8'h00 |=> !e2a_valid)
        else $error("negative notification answered");
    chk_note_follows: assert property (e2a_valid && e2a_frame.command_code == 8'h80 |=> is_note)
        else $error("data reply not followed by notification");
    chk_pulse_one: assert property (a2e_valid |=> !a2e_valid)
        else $error("adapter strobe longer than one cycle");
    chk_req_spacing: assert property (a2e_valid && a2e_frame.command_code == 8'h00 && armed_r
        |-> gap_cnt_r >= GAPC)
        else $error("request retried before the retry gap");
endmodule : alr_link_assertions
`default_nettype wire

// ---- bench/adapter_link_recognition_bench.sv ----
// self-checking bench: adapter and equipment face each other over the link
// assumes CYC_PER_MS shortened to 4 so that ms timing stays short
`timescale 1ns/100ps
`default_nettype none
module adapter_link_recognition_bench;
    import alr_pkg::*;
    typedef struct packed {logic [7:0] ifd; logic [2:0] mask; logic ok;} alr_row_s;
    localparam int C = 4;
    localparam alr_row_s ROWS [7] = '{'{8'h40, 3'h0, 1'b1}, '{8'hC0, 3'h0, 1'b1}, '{8'h80, 3'h7, 1'b0},
        '{8'h00, 3'h7, 1'b0}, '{8'h68, 3'h5, 1'b1}, '{8'h68, 3'h4, 1'b0}, '{8'hF8, 3'h7, 1'b1}};
    logic i_mclk;
    logic i_rst_b;
    logic [7:0] if_data;
    logic [2:0] feat;
    logic [4:0] ctl;
    alr_astate_e a_state;
    alr_estate_e e_state;
    logic [2:0] a_speed;
    logic [2:0] e_speed;
    logic [7:0] a_ifd;
    logic a_rec, a_conf, a_abort, e_rec, e_conf, e_rej;
    logic abort_seen, rej_seen, wrap_seen;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    alr_astate_e w_a_state;
    alr_estate_e w_e_state;
    logic w_a_rec, w_e_rec;
    alr_link_if u_alr_link_if();
    // ctl bits: 4 confirm fail, 3 reconfirm, 2 confirm ok, 1 recover ok, 0 comm fail
    alr_adapter #(.CYC_PER_MS(C)) u_alr_adapter (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(u_alr_link_if),
        .i_feat_mask(feat), .i_confirm_ok(ctl[2]), .i_confirm_fail(ctl[4]), .i_comm_fail(ctl[0]),
        .i_recover_ok(ctl[1]), .i_reconfirm(ctl[3]), .o_state(a_state), .o_speed(a_speed),
        .o_if_data(a_ifd), .o_recognized(a_rec), .o_confirmed(a_conf), .o_abort(a_abort));
    alr_equip #(.CYC_PER_MS(C)) u_alr_equip (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(u_alr_link_if),
        .i_speed(3'h2), .i_if_data(if_data), .i_confirm_ok(ctl[2]), .i_comm_fail(ctl[0]),
        .i_recover_ok(ctl[1]), .o_state(e_state), .o_speed(e_speed), .o_recognized(e_rec),
        .o_confirmed(e_conf), .o_rejected(e_rej));
    alr_link_assertions #(.CYC_PER_MS(C)) u_alr_link_assertions (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .a2e_valid(u_alr_link_if.a2e_valid), .a2e_frame(u_alr_link_if.a2e_frame),
        .e2a_valid(u_alr_link_if.e2a_valid), .e2a_frame(u_alr_link_if.e2a_frame));
    // second pair built to start recognized, checked at each reset release
    alr_link_if u_alr_link_if_warm();
    alr_adapter #(.CYC_PER_MS(C), .START_RECOG(1'b1)) u_alr_adapter_warm (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .link(u_alr_link_if_warm), .i_feat_mask(feat), .i_confirm_ok(ctl[2]), .i_confirm_fail(ctl[4]),
        .i_comm_fail(ctl[0]), .i_recover_ok(ctl[1]), .i_reconfirm(ctl[3]), .o_state(w_a_state), .o_speed(),
        .o_if_data(), .o_recognized(w_a_rec), .o_confirmed(), .o_abort());
    alr_equip #(.CYC_PER_MS(C), .START_RECOG(1'b1)) u_alr_equip_warm (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .link(u_alr_link_if_warm), .i_speed(3'h2), .i_if_data(if_data), .i_confirm_ok(ctl[2]),
        .i_comm_fail(ctl[0]), .i_recover_ok(ctl[1]), .o_state(w_e_state), .o_speed(), .o_recognized(w_e_rec),
        .o_confirmed(), .o_rejected());
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    // pulses are one cycle wide, so latch them for later comparison
    always @(posedge i_mclk) begin
        if (a_abort === 1'b1) abort_seen = 1'b1;
        if (e_rej === 1'b1) rej_seen = 1'b1;
        if (a_speed === 3'h0) wrap_seen = 1'b1;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task do_reset(input logic [7:0] d, input logic [2:0] m);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        if_data <= d;
        feat <= m;
        ctl <= 5'h00;
        repeat (4) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        abort_seen = 1'b0;
        rej_seen = 1'b0;
        check("adapter reset state", a_state, ALR_A_REQ);
        check("equip reset state", e_state, ALR_E_WREQ);
        check("reset speed", a_speed, 3'h2);
        check("warm start state", {w_a_state, w_e_state}, {ALR_A_UNCONF, ALR_E_UNCONF});
        check("warm start flags", {w_a_rec, w_e_rec}, 2'b11);
    endtask : do_reset
    // bounded wait for either of two adapter states; n keeps the cycles spent
    task wait_a(input alr_astate_e s1, input alr_astate_e s2, input int lim);
        n = 0;
        while (a_state !== s1 && a_state !== s2 && n < lim) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (n >= lim) check("adapter state", a_state, s1);
    endtask : wait_a
    task pulse(input logic [4:0] m);
        @(posedge i_mclk);
        ctl <= m;
        @(posedge i_mclk);
        ctl <= 5'h00;
        #1;
    endtask : pulse
    initial begin
        i_rst_b = 1'b0;
        if_data = 8'h00;
        feat = 3'h0;
        ctl = 5'h00;
        for (int i = 0; i < 7; i++) begin
            do_reset(ROWS[i].ifd, ROWS[i].mask);
            wait_a(ALR_A_TRANS, ALR_A_NOCONN, 100);
            repeat (3) @(posedge i_mclk);
            #1;
            check("adapter state", a_state, ROWS[i].ok ? ALR_A_TRANS : ALR_A_NOCONN);
            check("notification result", u_alr_link_if.a2e_frame.data, ROWS[i].ok ? 8'h00 : 8'h01);
            check("equip state", e_state, ROWS[i].ok ? ALR_E_TRANS : ALR_E_WREQ);
            check("abort pulse", abort_seen, !ROWS[i].ok);
            check("reject pulse", rej_seen, !ROWS[i].ok);
            check("interface data", a_ifd, ROWS[i].ifd);
        end
        do_reset(8'hC0, 3'h7);
        wait_a(ALR_A_TRANS, ALR_A_TRANS, 100);
        wait_a(ALR_A_UNCONF, ALR_A_UNCONF, 2200);
        check("switch delay met", n >= 500 * C, 1'b1);
        check("equip unconfirmed", e_state, ALR_E_UNCONF);
        check("recognized flags", {a_rec, e_rec, a_conf}, 3'b110);
        pulse(5'h04);
        check("confirmed", {a_conf, e_conf}, 2'b11);
        pulse(5'h08);
        check("reconfirm", a_state, ALR_A_UNCONF);
        // confirmation failure and comm failure share one recovery count
        pulse(5'h10);
        pulse(5'h01);
        check("still recovering", {a_state, e_state}, {ALR_A_UNCONF, ALR_E_CONF});
        pulse(5'h02);
        pulse(5'h04);
        pulse(5'h01);
        pulse(5'h01);
        check("after recovery", {a_conf, e_conf}, 2'b11);
        wrap_seen = 1'b0;
        pulse(5'h01);
        check("adapter fallback", a_state, ALR_A_GAP);
        check("equip fallback", e_state, ALR_E_WREQ);
        check("recognition dropped", {a_rec, e_rec}, 2'b00);
        wait_a(ALR_A_TRANS, ALR_A_TRANS, 15000);
        check("speed wrap", wrap_seen, 1'b1);
        check("recognized speed", {a_speed, e_speed}, 6'h12);
        finish_test;
    end
    // whole run is about 12000 cycles
    initial begin
        repeat (40000) @(posedge i_mclk);
        fail_count++;
        finish_test;
    end
endmodule : adapter_link_recognition_bench
`default_nettype wire
